// ### hw/sesr_flag_latch.sv
// sesr_flag_latch: sticky event flags, cleared by a read, set wins
`timescale 1ns/1ps
`default_nettype none
module sesr_flag_latch #(
	parameter int          W         = 8,
	parameter logic [7:0]  RESET_VAL = 8'h80,
	parameter logic [7:0]  KEEP_BITS = 8'hBD
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic [W-1:0]  set_vec,
	input  wire logic          clr,
	output logic      [W-1:0]  flags_q
);
	import sesr_pkg::*;

	// ==========================================================
	// next value
	logic [W-1:0] flags_d;
	logic [W-1:0] held;
	// a set in the clearing cycle survives the clear
	assign held    = clr ? W'(ZERO_BYTE) : flags_q;
	assign flags_d = (held | set_vec) & W'(KEEP_BITS);

	// flag store
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flags_q <= W'(RESET_VAL & KEEP_BITS);
		end else begin
			flags_q <= flags_d;
		end
	end

	// ==========================================================
	// checks
	AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(set_vec & W'(KEEP_BITS)) != '0 |=>
			(flags_q & $past(set_vec & W'(KEEP_BITS)))
			== $past(set_vec & W'(KEEP_BITS)))
		else $error("flag set lost");

endmodule : sesr_flag_latch
`default_nettype wire

// ### hw/sesr_opc_track.sv
// sesr_opc_track: waits for pending work after an operation complete command
`timescale 1ns/1ps
`default_nettype none
module sesr_opc_track (
	input  wire logic  ref_clk,
	input  wire logic  rst_n,
	input  wire logic  opc_cmd,
	input  wire logic  ops_busy,
	output logic       done_q
);
	import sesr_pkg::*;

	// ==========================================================
	// state machine
	sesr_opc_state_t state_q;
	sesr_opc_state_t state_d;
	logic            done_d;

	// arm on the command, report once work has drained
	always_comb begin
		state_d = state_q;
		done_d  = 1'b0;
		case (state_q)
			OPC_IDLE: begin
				if (opc_cmd && !ops_busy) begin
					done_d = 1'b1;
				end else if (opc_cmd) begin
					state_d = OPC_ARMED;
				end
			end
			OPC_ARMED: begin
				if (!ops_busy) begin
					done_d  = 1'b1;
					state_d = OPC_IDLE;
				end
			end
			default: begin
				state_d = OPC_IDLE;
			end
		endcase
	end

	// state and pulse registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= OPC_IDLE;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q  <= done_d;
		end
	end

	// ==========================================================
	// checks
	AST_OPC_ARMED_DONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q == OPC_ARMED && !ops_busy |=> done_q && state_q == OPC_IDLE)
		else $error("armed completion not reported");

	AST_OPC_NO_EARLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q == OPC_ARMED && ops_busy |=> !done_q)
		else $error("completion reported while busy");

endmodule : sesr_opc_track
`default_nettype wire

// ### hw/sesr_pkg.sv
// sesr_pkg: shared constants and types of the standard event status block
`default_nettype none
package sesr_pkg;

	// ==========================================================
	// register geometry
	localparam int          REG_W       = 8;
	localparam logic [7:0]  FLAGS_RESET = 8'h80;  // power-on flag set
	localparam logic [7:0]  MASK_RESET  = 8'h00;
	localparam logic [7:0]  UNUSED_BITS = 8'h42;  // positions 1 and 6
	localparam logic [7:0]  VALID_BITS  = 8'hBD;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;

	// ==========================================================
	// flag positions within the event register
	localparam int BIT_OPC = 0;
	localparam int BIT_QYE = 2;
	localparam int BIT_DDE = 3;
	localparam int BIT_EXE = 4;
	localparam int BIT_CME = 5;
	localparam int BIT_PON = 7;

	// summary enable position in the service request enable value
	localparam int SRE_ESB_BIT = 5;

	// ==========================================================
	// operation complete tracker states
	typedef enum logic [1:0] {
		OPC_IDLE  = 2'b01,
		OPC_ARMED = 2'b10
	} sesr_opc_state_t;

endpackage : sesr_pkg
`default_nettype wire

// ### hw/sesr_regs.sv
// sesr_regs: standard event flags, their enable mask and summary outputs
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Positions 1 and 6 of the event register are never set by any event.
// - A service request is signalled only for an enabled flag with SRE bit 5 set.
// - The enable-mask command loads the mask from the supplied weighted sum.
// - The enable-mask query returns the mask and leaves it unchanged.
// - The event register query returns the flags and then clears all but any flag set in that same cycle.
// - The power-on flag at position 7 is set after a power off and on cycle.
// - The command error flag at position 5 is set on an uninterpretable command.
// - The execution error flag at position 4 is set on an impossible action.
// - The device error flag at position 3 is set on a device-specific fault.
// - The query error flag at position 2 is set when response data is lost.
// - The completion flag at position 0 is set once pending work has finished.
// - The summary bit is set while any enabled event flag is set.
module sesr_regs (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        ese_wr,
	input  wire logic [sesr_pkg::REG_W-1:0]  ese_data,
	input  wire logic                        ese_rd,
	input  wire logic                        esr_rd,
	input  wire logic [sesr_pkg::REG_W-1:0]  sre_value,
	input  wire logic                        pon_event_async,
	input  wire logic                        cmd_err,
	input  wire logic                        exe_err,
	input  wire logic                        dev_err,
	input  wire logic                        qry_err,
	input  wire logic                        opc_cmd,
	input  wire logic                        ops_busy,
	output logic                             resp_valid_q,
	output logic      [sesr_pkg::REG_W-1:0]  resp_data_q,
	output logic                             esb_summary_q,
	output logic                             event_srq_q
);
	import sesr_pkg::*;

	// ==========================================================
	// power monitor input synchroniser
	logic pon_meta_q;
	logic pon_sync_q;
	logic pon_prev_q;
	logic pon_rise;

	// two stages before any logic sees the monitor level
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pon_meta_q <= 1'b0;
			pon_sync_q <= 1'b0;
			pon_prev_q <= 1'b0;
		end else begin
			pon_meta_q <= pon_event_async;
			pon_sync_q <= pon_meta_q;
			pon_prev_q <= pon_sync_q;
		end
	end

	// a fresh off-on cycle reported by the monitor; the history
	// flop resets to the idle level, so reset gives no false edge
	assign pon_rise = pon_sync_q && !pon_prev_q;

	// ==========================================================
	// operation complete tracking
	logic opc_done_q;

	sesr_opc_track u_opc (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.opc_cmd  (opc_cmd),
		.ops_busy (ops_busy),
		.done_q   (opc_done_q)
	);

	// ==========================================================
	// event set vector
	logic [REG_W-1:0] set_vec;
	logic [REG_W-1:0] flags_q;

	// each event steers its own flag, unused positions stay low
	always_comb begin
		set_vec          = ZERO_BYTE;
		set_vec[BIT_PON] = pon_rise;
		set_vec[BIT_CME] = cmd_err;
		set_vec[BIT_EXE] = exe_err;
		set_vec[BIT_DDE] = dev_err;
		set_vec[BIT_QYE] = qry_err;
		set_vec[BIT_OPC] = opc_done_q;
	end

	// sticky flags, cleared by the event register query
	sesr_flag_latch #(
		.W         (REG_W),
		.RESET_VAL (FLAGS_RESET),
		.KEEP_BITS (VALID_BITS)
	) u_flags (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.set_vec (set_vec),
		.clr     (esr_rd),
		.flags_q (flags_q)
	);

	// ==========================================================
	// enable mask
	logic [REG_W-1:0] mask_q;
	logic [REG_W-1:0] mask_d;

	// weighted sum loaded as is, unused positions dropped
	assign mask_d = ese_wr ? (ese_data & VALID_BITS) : mask_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mask_q <= MASK_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	// ==========================================================
	// query responses
	logic             resp_valid_d;
	logic [REG_W-1:0] resp_data_d;

	// event query outranks mask query in the same cycle; data
	// holds between queries while valid pulses for one cycle
	assign resp_valid_d = esr_rd || ese_rd;
	assign resp_data_d  = esr_rd ? flags_q
	                    : ese_rd ? mask_q
	                    : resp_data_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			resp_valid_q <= 1'b0;
			resp_data_q  <= ZERO_BYTE;
		end else begin
			resp_valid_q <= resp_valid_d;
			resp_data_q  <= resp_data_d;
		end
	end

	// ==========================================================
	// summary and service request
	logic esb_now;
	logic srq_now;

	// true when some flag is let through by its enable bit
	function automatic logic any_enabled(
		input logic [REG_W-1:0] flags,
		input logic [REG_W-1:0] mask
	);
		return |(flags & mask);
	endfunction : any_enabled

	// both outputs lag the flags by one cycle, never combinational
	assign esb_now = any_enabled(flags_q, mask_q);
	assign srq_now = esb_now && sre_value[SRE_ESB_BIT];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			esb_summary_q <= 1'b0;
			event_srq_q   <= 1'b0;
		end else begin
			esb_summary_q <= esb_now;
			event_srq_q   <= srq_now;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_UNUSED_FLAGS: assert property (
		(flags_q & UNUSED_BITS) == ZERO_BYTE)
		else $error("unused flag position set");

	AST_SRQ_GATED: assert property (
		event_srq_q |-> $past(sre_value[SRE_ESB_BIT])
			&& $past(any_enabled(flags_q, mask_q)))
		else $error("request without enabled flag and sre bit");

	AST_SRQ_RAISED: assert property (
		cmd_err && mask_q[BIT_CME] && !ese_wr && !esr_rd
			&& sre_value[SRE_ESB_BIT] ##1 sre_value[SRE_ESB_BIT]
			|=> event_srq_q)
		else $error("enabled error did not request service");

	AST_MASK_LOAD: assert property (
		ese_wr |=> mask_q == ($past(ese_data) & VALID_BITS))
		else $error("mask not loaded");

	AST_MASK_QUERY: assert property (
		ese_rd && !esr_rd && !ese_wr |=> resp_valid_q
			&& resp_data_q == $past(mask_q) && mask_q == $past(mask_q))
		else $error("mask query wrong or disturbing");

	AST_FLAG_QUERY: assert property (
		esr_rd |=> resp_valid_q && resp_data_q == $past(flags_q))
		else $error("flag query returned wrong value");

	AST_FLAG_CLEAR: assert property (
		esr_rd && set_vec == ZERO_BYTE |=> flags_q == ZERO_BYTE)
		else $error("flags not cleared by query");

	AST_PON_SET: assert property (
		$rose(pon_sync_q) |=> flags_q[BIT_PON])
		else $error("power-on flag missing");

	AST_CME_SET: assert property (
		cmd_err |=> flags_q[BIT_CME])
		else $error("command error flag missing");

	AST_EXE_SET: assert property (
		exe_err |=> flags_q[BIT_EXE])
		else $error("execution error flag missing");

	AST_DDE_SET: assert property (
		dev_err |=> flags_q[BIT_DDE])
		else $error("device error flag missing");

	AST_QYE_SET: assert property (
		qry_err |=> flags_q[BIT_QYE])
		else $error("query error flag missing");

	AST_OPC_SET: assert property (
		opc_cmd && !ops_busy ##1 1'b1 |=> flags_q[BIT_OPC])
		else $error("completion flag missing");

	AST_SUMMARY: assert property (
		##1 esb_summary_q == $past(any_enabled(flags_q, mask_q)))
		else $error("summary bit disagrees with enabled flags");

	AST_MASK_UNUSED: assert property (
		(mask_q & UNUSED_BITS) == ZERO_BYTE)
		else $error("unused enable bit stored");

	// ==========================================================
	// holding and gating behaviour between events
	AST_SRQ_NEEDS_SRE: assert property (
		!sre_value[SRE_ESB_BIT] |=> !event_srq_q)
		else $error("request raised with sre bit clear");

	AST_SRQ_IN_SUMMARY: assert property (
		event_srq_q |-> esb_summary_q)
		else $error("request raised without summary bit");

	AST_SRQ_NO_FLAGS: assert property (
		flags_q == ZERO_BYTE |=> !event_srq_q)
		else $error("request raised with no flag set");

	AST_MASK_WRITE_READ: assert property (
		ese_wr && ese_rd && !esr_rd |=> resp_data_q == $past(mask_q))
		else $error("mask query in load cycle not old mask");

	AST_MASK_HOLD: assert property (
		!ese_wr |=> mask_q == $past(mask_q))
		else $error("mask changed without a load");

	AST_RESP_IDLE: assert property (
		!esr_rd && !ese_rd |=> !resp_valid_q
			&& resp_data_q == $past(resp_data_q))
		else $error("response moved without a query");

	AST_BOTH_QUERY: assert property (
		esr_rd && ese_rd && !ese_wr |=> resp_data_q == $past(flags_q)
			&& mask_q == $past(mask_q))
		else $error("joint query did not return the flags");

	AST_FLAG_HOLD: assert property (
		!esr_rd && set_vec == ZERO_BYTE |=> flags_q == $past(flags_q))
		else $error("flags changed without event or query");

	AST_PON_ONCE: assert property (
		pon_rise |=> !pon_rise)
		else $error("one power cycle seen twice");

	AST_OPC_TO_FLAG: assert property (
		opc_done_q |=> flags_q[BIT_OPC])
		else $error("completion pulse did not set its flag");

	AST_OPC_NO_SPURIOUS: assert property (
		!opc_done_q && !flags_q[BIT_OPC] |=> !flags_q[BIT_OPC])
		else $error("completion flag set without completion");

	AST_SUMMARY_MASKED: assert property (
		mask_q == ZERO_BYTE |=> !esb_summary_q)
		else $error("summary set with every flag disabled");

	AST_ESB_NO_FLAGS: assert property (
		flags_q == ZERO_BYTE |=> !esb_summary_q)
		else $error("summary set with no flag set");

	// main scenarios
	COV_FLAG_READ: cover property (
		flags_q != ZERO_BYTE && esr_rd ##1 resp_valid_q);
	COV_SRQ: cover property (ese_wr ##[1:20] event_srq_q);
	COV_SET_ON_CLEAR: cover property (esr_rd && cmd_err);
	COV_OPC_WAIT: cover property (opc_cmd && ops_busy ##[1:20] opc_done_q);
	COV_PON_FLAG: cover property ($rose(pon_sync_q) ##1 flags_q[BIT_PON]);

endmodule : sesr_regs
`default_nettype wire

// ### verification/sesr_host_model.sv
// sesr_host_model: command-parser side issuing mask and flag queries
`timescale 1ns/1ps
`default_nettype none
module sesr_host_model (
	input  wire logic                        ref_clk,
	input  wire logic                        resp_valid_q,
	input  wire logic [sesr_pkg::REG_W-1:0]  resp_data_q,
	output var  logic                        ese_wr,
	output var  logic [sesr_pkg::REG_W-1:0]  ese_data,
	output var  logic                        ese_rd,
	output var  logic                        esr_rd,
	output var  logic [sesr_pkg::REG_W-1:0]  sre_value
);
	import sesr_pkg::*;

	// ==========================================================
	// idle levels at time zero
	initial begin
		ese_wr    = 1'b0;
		ese_data  = 8'h5A;
		ese_rd    = 1'b0;
		esr_rd    = 1'b0;
		sre_value = 8'h00;
	end

	// adds the weight of every wanted position
	function automatic logic [7:0] weigh(input logic [7:0] sel);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (sel[i]) begin
				s = s + (8'h01 << i);
			end
		end
		return s;
	endfunction : weigh

	// mask load, data scrambled once released
	task automatic write_mask(input logic [7:0] sel);
		ese_data = weigh(sel);
		ese_wr   = 1'b1;
		@(negedge ref_clk);
		ese_wr   = 1'b0;
		ese_data = ~ese_data;
		@(negedge ref_clk);
	endtask : write_mask

	// one query, answer taken one cycle after the strobe
	task automatic query(input logic mask_sel, output logic [8:0] r);
		ese_rd = mask_sel;
		esr_rd = !mask_sel;
		@(negedge ref_clk);
		r      = {resp_valid_q, resp_data_q};
		ese_rd = 1'b0;
		esr_rd = 1'b0;
		@(negedge ref_clk);
	endtask : query

	// service request enable value
	task automatic set_sre(input logic [7:0] v);
		sre_value = v;
	endtask : set_sre
endmodule : sesr_host_model
`default_nettype wire

// ### verification/tb.sv
// tb: self-checking bench of the standard event status block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sesr_pkg::*;
	logic        ref_clk, rst_n, pon, opc, busy;
	logic        ese_wr, ese_rd, esr_rd, rv, esb, srq;
	logic [3:0]  ev;
	logic [7:0]  ese_data, sre, rd;
	logic [8:0]  r;
	int          fails, checked, cyc;

	sesr_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .ese_wr(ese_wr),
		.ese_data(ese_data), .ese_rd(ese_rd), .esr_rd(esr_rd),
		.sre_value(sre), .pon_event_async(pon), .cmd_err(ev[3]),
		.exe_err(ev[2]), .dev_err(ev[1]), .qry_err(ev[0]),
		.opc_cmd(opc), .ops_busy(busy), .resp_valid_q(rv),
		.resp_data_q(rd), .esb_summary_q(esb), .event_srq_q(srq));
	sesr_host_model host (.ref_clk(ref_clk), .resp_valid_q(rv),
		.resp_data_q(rd), .ese_wr(ese_wr), .ese_data(ese_data),
		.ese_rd(ese_rd), .esr_rd(esr_rd), .sre_value(sre));

	// ==========================================================
	// clock and hang guard
	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 1000) begin
			fails++;
			end_of_test();
		end
	end

	// ==========================================================
	// compares and verdict
	task automatic chk_resp(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic end_of_test;
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// ==========================================================
	// main sequence
	initial begin
		ref_clk = 1'b0; rst_n = 1'b0; pon = 1'b0; opc = 1'b0;
		busy = 1'b0; ev = 4'h0; fails = 0; checked = 0; cyc = 0;
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		host.query(1'b0, r); chk_resp(r, 9'h180);
		host.query(1'b0, r); chk_resp(r, 9'h100);
		host.query(1'b1, r); chk_resp(r, 9'h100);
		host.write_mask(8'hFF);
		host.query(1'b1, r); chk_resp(r, 9'h1BD);
		host.query(1'b1, r); chk_resp(r, 9'h1BD);
		// each error source, summary and request gating
		for (int i = 0; i < 4; i++) begin
			host.set_sre(i[0] ? 8'h20 : 8'hDF);
			ev[i] = 1'b1;
			@(negedge ref_clk);
			ev = 4'h0;
			@(negedge ref_clk);
			chk_bit(esb, 1'b1);
			chk_bit(srq, i[0]);
			host.query(1'b0, r);
			chk_resp(r, {1'b1, 8'h04 << i});
		end
		// disabled flag gives no summary
		host.write_mask(8'h04);
		ev[3] = 1'b1; @(negedge ref_clk); ev = 4'h0; @(negedge ref_clk);
		chk_bit(esb, 1'b0);
		ev[0] = 1'b1; @(negedge ref_clk); ev = 4'h0; @(negedge ref_clk);
		chk_bit(esb, 1'b1);
		chk_bit(srq, 1'b1);
		host.query(1'b0, r); chk_resp(r, 9'h124);
		chk_bit(esb, 1'b0);
		// event in the clearing cycle survives
		fork
			host.query(1'b0, r);
			begin
				ev[3] = 1'b1;
				@(negedge ref_clk);
				ev = 4'h0;
			end
		join
		chk_resp(r, 9'h100);
		host.query(1'b0, r); chk_resp(r, 9'h120);
		// completion waits for pending work
		busy = 1'b1; opc = 1'b1; @(negedge ref_clk); opc = 1'b0;
		repeat (4) @(negedge ref_clk);
		host.query(1'b0, r); chk_resp(r, 9'h100);
		busy = 1'b0;
		repeat (3) @(negedge ref_clk);
		host.query(1'b0, r); chk_resp(r, 9'h101);
		// power cycle seen by the monitor
		pon = 1'b1; repeat (6) @(negedge ref_clk); pon = 1'b0;
		host.query(1'b0, r); chk_resp(r, 9'h180);
		// every source at once leaves the unused positions clear
		ev = 4'hF; opc = 1'b1; pon = 1'b1;
		@(negedge ref_clk);
		ev = 4'h0; opc = 1'b0;
		repeat (5) @(negedge ref_clk);
		host.query(1'b0, r); chk_resp(r, 9'h1BD);
		pon = 1'b0;
		rst_n = 1'b0; repeat (2) @(negedge ref_clk); rst_n = 1'b1; // mid-run
		host.query(1'b1, r); chk_resp(r, 9'h100);
		host.query(1'b0, r); chk_resp(r, 9'h180);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
